/* rtl/fdcfg_consts.svh */
// fdcfg_consts.svh: indices, field positions, reset values and masks of the
// floppy logical device configuration bank.
// assumes it is included by its bare name; guarded against double inclusion.
//
// What this block does
// - only power-on/hard reset restores defaults; soft keeps
// - mode bit 0 selects normal or enhanced mode
// - mode bit 1: 0 burst, 1 non-burst DMA
// - mode bits 3:2 select interface personality
// - mode bit 6: open drain or push-pull floppy pins
// - mode bit 7 tri-states; parallel pins unaffected
// - option bit 0 forces write protect when selected
// - write protect is OR of four terms
// - forced write protect also on parallel-port pins
// - option bits 3:2 force or pass density
// - type register stores four two-bit drive types
// - reserved index reads zero, ignores writes
// - per-drive type, rate fields; bits 2,5,7 zero
// - per-drive bit 6 disables write precompensation
// - second per-drive register same, for drive one
// - drive zero boots; exactly two drives
`ifndef FDCFG_CONSTS_SVH
`define FDCFG_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices behind the data port
`define FDCFG_IDX_MODE    8'hF0
`define FDCFG_IDX_OPTION  8'hF1
`define FDCFG_IDX_TYPE    8'hF2
`define FDCFG_IDX_RSVD    8'hF3
`define FDCFG_IDX_DRV0    8'hF4
`define FDCFG_IDX_DRV1    8'hF5

////////////////////////////////////////////////////////////////////////////////
// reset values
`define FDCFG_MODE_RST    8'h0E
`define FDCFG_OPTION_RST  8'h00
`define FDCFG_TYPE_RST    8'hFF
`define FDCFG_DRV_RST     8'h00
`define FDCFG_INDEX_RST   8'h00

////////////////////////////////////////////////////////////////////////////////
// mode register fields
`define FDCFG_MODE_ENH    0
`define FDCFG_MODE_DMA    1
`define FDCFG_MODE_IFM_LO 2
`define FDCFG_MODE_IFM_HI 3
`define FDCFG_MODE_PP     6
`define FDCFG_MODE_TRI    7

// option register fields
`define FDCFG_OPT_FWP     0
`define FDCFG_OPT_DEN_LO  2
`define FDCFG_OPT_DEN_HI  3
`define FDCFG_DEN_HIGH    2'h2
`define FDCFG_DEN_LOW     2'h3

// type register fields
`define FDCFG_TYPE_A_LO   0
`define FDCFG_TYPE_A_HI   1
`define FDCFG_TYPE_B_LO   2
`define FDCFG_TYPE_B_HI   3

// per-drive register fields
`define FDCFG_DRV_DT_LO   0
`define FDCFG_DRV_DT_HI   1
`define FDCFG_DRV_DRT_LO  3
`define FDCFG_DRV_DRT_HI  4
`define FDCFG_DRV_PTS     6
`define FDCFG_DRV_MASK    8'h5B

////////////////////////////////////////////////////////////////////////////////
// pin bundle width and boot drive
`define FDCFG_NPINS       8
`define FDCFG_BOOT_DRIVE  1'h0

`endif

/* rtl/fdcfg_pkg.sv */
// fdcfg_pkg: state types of the floppy configuration bank and its helpers.
// assumes fdcfg_consts.svh is on the include path.
`include "fdcfg_consts.svh"

package fdcfg_pkg;

  // whole state of the register bank
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] mode;
    logic [7:0] option;
    logic [7:0] dtype;
    logic [7:0] drv0;
    logic [7:0] drv1;
    logic [7:0] rdata;
    logic       rvalid;
    logic       density;
  } fdcfg_regs_s;

  // write protect combiner state
  typedef struct packed {
    logic [2:0] sync;
    logic       wp_n_filt;
    logic       wp_n_out;
  } fdcfg_wp_s;

  // pin driver state
  typedef struct packed {
    logic [`FDCFG_NPINS-1:0] out;
    logic [`FDCFG_NPINS-1:0] oe;
  } fdcfg_pin_s;

endpackage : fdcfg_pkg

/* rtl/fdcfg_wp_comb.sv */
// fdcfg_wp_comb: combined write protect toward the controller core.
// assumes wp_pin_n comes from a pin; drive selects and control bits come
// from logic on clk.
module fdcfg_wp_comb (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // drive side
  input  wire logic wp_pin_n,
  input  wire logic ds0_n,
  input  wire logic ds1_n,
  // control
  input  wire logic force_wp,
  input  wire logic global_wp,
  // to core
  output logic      write_protect_n
);
  import fdcfg_pkg::*;

  fdcfg_wp_s r;
  fdcfg_wp_s next_r;

  // pin sync, agreement filter and the four-term or
  always_comb begin
    next_r         = r;
    next_r.sync[0] = wp_pin_n;
    next_r.sync[1] = r.sync[0];
    next_r.sync[2] = r.sync[1];
    if (r.sync[1] == r.sync[2]) begin
      next_r.wp_n_filt = r.sync[2];
    end
    next_r.wp_n_out = ~(global_wp | ~r.wp_n_filt |
                        (~ds0_n & force_wp) | (~ds1_n & force_wp));
  end

  // state register, inactive levels at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{sync: 3'h7, wp_n_filt: 1'h1, wp_n_out: 1'h1};
    end else begin
      r <= next_r;
    end
  end

  assign write_protect_n = r.wp_n_out;

endmodule : fdcfg_wp_comb

/* rtl/fdcfg_pin_drv.sv */
// fdcfg_pin_drv: registered driver for a bundle of controller output pins.
// assumes the pad works out the wire from out and oe; oe high drives.
`include "fdcfg_consts.svh"
module fdcfg_pin_drv (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // control
  input  wire logic                    active,
  input  wire logic                    push_pull_driver,
  // core values
  input  wire logic [`FDCFG_NPINS-1:0] core_out,
  // pad side
  output logic      [`FDCFG_NPINS-1:0] pin_out,
  output logic      [`FDCFG_NPINS-1:0] pin_oe
);
  import fdcfg_pkg::*;

  fdcfg_pin_s              r;
  fdcfg_pin_s              next_r;
  logic [`FDCFG_NPINS-1:0] nxt_out;
  logic [`FDCFG_NPINS-1:0] nxt_oe;

  // per pin: open drain only pulls low, push-pull drives both levels
  for (genvar i = 0; i < `FDCFG_NPINS; i++) begin : g_pin
    assign nxt_out[i] = push_pull_driver & core_out[i];
    assign nxt_oe[i]  = active & (push_pull_driver | ~core_out[i]);
  end

  // next state
  always_comb begin
    next_r     = r;
    next_r.out = nxt_out;
    next_r.oe  = nxt_oe;
  end

  // state register, pins released at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{out: '0, oe: '0};
    end else begin
      r <= next_r;
    end
  end

  assign pin_out = r.out;
  assign pin_oe  = r.oe;

endmodule : fdcfg_pin_drv

/* rtl/fdcfg_config_regs.sv */
// fdcfg_config_regs: floppy logical device configuration bank behind the
// configuration index/data port pair, with write protect and pin control.
// assumes port decode and logical device selection are done outside;
// rst is the power-on or hard reset, soft_rst the soft reset.
`include "fdcfg_consts.svh"
module fdcfg_config_regs (
  // clock and resets
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    soft_rst,
  // configuration port
  input  wire logic                    io_wr,
  input  wire logic                    io_rd,
  input  wire logic                    io_data_sel,
  input  wire logic [7:0]              io_wdata,
  input  wire logic                    ldev_active,
  output logic      [7:0]              io_rdata,
  output logic                         io_rvalid,
  // mode outputs
  output logic                         enhanced_mode,
  output logic                         non_burst_dma,
  output logic      [1:0]              interface_mode,
  // drive settings
  output logic      [1:0]              drive_type_a,
  output logic      [1:0]              drive_type_b,
  output logic      [1:0]              drive0_type_select,
  output logic      [1:0]              drive0_rate_table_select,
  output logic                         drive0_precomp_off,
  output logic      [1:0]              drive1_type_select,
  output logic      [1:0]              drive1_rate_table_select,
  output logic                         drive1_precomp_off,
  output logic                         boot_drive,
  // write protect, floppy pins
  input  wire logic                    write_protect_n_input,
  input  wire logic                    drive_select0_n,
  input  wire logic                    drive_select1_n,
  input  wire logic                    floppy_write_protect,
  output logic                         core_write_protect_n,
  output logic                         status_register_a_wp,
  // write protect, parallel-port pins
  input  wire logic                    pp_write_protect_n_input,
  input  wire logic                    pp_drive_select0_n,
  input  wire logic                    pp_drive_select1_n,
  output logic                         pp_core_write_protect_n,
  // density
  input  wire logic                    core_density,
  output logic                         density_out,
  // controller output pins
  input  wire logic [`FDCFG_NPINS-1:0] core_pin_out,
  output logic      [`FDCFG_NPINS-1:0] fdc_pin_out,
  output logic      [`FDCFG_NPINS-1:0] fdc_pin_oe,
  // floppy outputs routed over the parallel port
  input  wire logic                    pp_route_en,
  input  wire logic [`FDCFG_NPINS-1:0] pp_core_pin_out,
  output logic      [`FDCFG_NPINS-1:0] pp_pin_out,
  output logic      [`FDCFG_NPINS-1:0] pp_pin_oe
);
  import fdcfg_pkg::*;

  fdcfg_regs_s r;
  fdcfg_regs_s next_r;
  logic        wr_data;
  logic        rd_data;
  logic [7:0]  data_view;
  logic        push_pull_driver;
  logic        open_drain_driver;
  logic        fdc_active;

  //////////////////////////////////////////////////////////////////////////////
  // access decode: data port writes only count while this device is selected
  assign wr_data = io_wr & io_data_sel & ldev_active;
  assign rd_data = io_rd & io_data_sel;

  // data port read view, unmapped indices and other devices read zero
  always_comb begin
    data_view = 8'h00;
    if (ldev_active) begin
      case (r.index)
        `FDCFG_IDX_MODE:   data_view = r.mode;
        `FDCFG_IDX_OPTION: data_view = r.option;
        `FDCFG_IDX_TYPE:   data_view = r.dtype;
        `FDCFG_IDX_RSVD:   data_view = 8'h00;
        `FDCFG_IDX_DRV0:   data_view = r.drv0 & `FDCFG_DRV_MASK;
        `FDCFG_IDX_DRV1:   data_view = r.drv1 & `FDCFG_DRV_MASK;
        default:           data_view = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: index latch, register writes, read capture, density
  always_comb begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    if (io_wr && !io_data_sel) begin
      next_r.index = io_wdata;
    end
    if (wr_data) begin
      case (r.index)
        `FDCFG_IDX_MODE:   next_r.mode   = io_wdata;
        `FDCFG_IDX_OPTION: next_r.option = io_wdata;
        `FDCFG_IDX_TYPE:   next_r.dtype  = io_wdata;
        `FDCFG_IDX_DRV0:   next_r.drv0   = io_wdata & `FDCFG_DRV_MASK;
        `FDCFG_IDX_DRV1:   next_r.drv1   = io_wdata & `FDCFG_DRV_MASK;
        default:           next_r.index  = r.index;
      endcase
    end
    // soft reset only drops the index, the bank itself is kept; it comes
    // after the write branches so that none of them can restore the old index over it
    if (soft_rst) begin
      next_r.index = `FDCFG_INDEX_RST;
    end
    if (io_rd) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = io_data_sel ? data_view : r.index;
    end
    // density: forced high, forced low, or passed through
    case (r.option[`FDCFG_OPT_DEN_HI:`FDCFG_OPT_DEN_LO])
      `FDCFG_DEN_HIGH: next_r.density = 1'b1;
      `FDCFG_DEN_LOW:  next_r.density = 1'b0;
      default:         next_r.density = core_density;
    endcase
  end

  // bank register; only rst restores defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{index:   `FDCFG_INDEX_RST,
             mode:    `FDCFG_MODE_RST,
             option:  `FDCFG_OPTION_RST,
             dtype:   `FDCFG_TYPE_RST,
             drv0:    `FDCFG_DRV_RST,
             drv1:    `FDCFG_DRV_RST,
             rdata:   8'h00,
             rvalid:  1'b0,
             density: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register field outputs
  assign io_rdata       = r.rdata;
  assign io_rvalid      = r.rvalid;
  assign enhanced_mode  = r.mode[`FDCFG_MODE_ENH];
  assign non_burst_dma  = r.mode[`FDCFG_MODE_DMA];
  assign interface_mode = r.mode[`FDCFG_MODE_IFM_HI:`FDCFG_MODE_IFM_LO];
  assign drive_type_a   = r.dtype[`FDCFG_TYPE_A_HI:`FDCFG_TYPE_A_LO];
  assign drive_type_b   = r.dtype[`FDCFG_TYPE_B_HI:`FDCFG_TYPE_B_LO];
  assign density_out    = r.density;

  // per-drive fields, two drives only
  assign drive0_type_select       = r.drv0[`FDCFG_DRV_DT_HI:`FDCFG_DRV_DT_LO];
  assign drive0_rate_table_select = r.drv0[`FDCFG_DRV_DRT_HI:`FDCFG_DRV_DRT_LO];
  assign drive0_precomp_off       = r.drv0[`FDCFG_DRV_PTS];
  assign drive1_type_select       = r.drv1[`FDCFG_DRV_DT_HI:`FDCFG_DRV_DT_LO];
  assign drive1_rate_table_select = r.drv1[`FDCFG_DRV_DRT_HI:`FDCFG_DRV_DRT_LO];
  assign drive1_precomp_off       = r.drv1[`FDCFG_DRV_PTS];
  assign boot_drive               = `FDCFG_BOOT_DRIVE;

  //////////////////////////////////////////////////////////////////////////////
  // write protect toward the core, once for each pin route
  fdcfg_wp_comb u_wp_fdc (
    .clk             (clk),
    .rst             (rst),
    .wp_pin_n        (write_protect_n_input),
    .ds0_n           (drive_select0_n),
    .ds1_n           (drive_select1_n),
    .force_wp        (r.option[`FDCFG_OPT_FWP]),
    .global_wp       (floppy_write_protect),
    .write_protect_n (core_write_protect_n)
  );

  // parallel-port route sees the same force
  fdcfg_wp_comb u_wp_pp (
    .clk             (clk),
    .rst             (rst),
    .wp_pin_n        (pp_write_protect_n_input),
    .ds0_n           (pp_drive_select0_n),
    .ds1_n           (pp_drive_select1_n),
    .force_wp        (r.option[`FDCFG_OPT_FWP]),
    .global_wp       (floppy_write_protect),
    .write_protect_n (pp_core_write_protect_n)
  );

  // status register a reports the combined write protect
  assign status_register_a_wp = ~core_write_protect_n;

  //////////////////////////////////////////////////////////////////////////////
  // output pin drivers; mode bits 6 and 7 reach only the floppy pins
  assign push_pull_driver  = r.mode[`FDCFG_MODE_PP];
  assign open_drain_driver = ~push_pull_driver;
  assign fdc_active        = ~r.mode[`FDCFG_MODE_TRI];

  fdcfg_pin_drv u_pins_fdc (
    .clk              (clk),
    .rst              (rst),
    .active           (fdc_active),
    .push_pull_driver (push_pull_driver),
    .core_out         (core_pin_out),
    .pin_out          (fdc_pin_out),
    .pin_oe           (fdc_pin_oe)
  );

  // parallel-port route: always push-pull, enabled by the route alone
  fdcfg_pin_drv u_pins_pp (
    .clk              (clk),
    .rst              (rst),
    .active           (pp_route_en),
    .push_pull_driver (1'b1),
    .core_out         (pp_core_pin_out),
    .pin_out          (pp_pin_out),
    .pin_oe           (pp_pin_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reset_defaults: assert property (disable iff (1'b0) rst |=>
    r.mode == `FDCFG_MODE_RST && r.option == `FDCFG_OPTION_RST &&
    r.dtype == `FDCFG_TYPE_RST && r.drv0 == `FDCFG_DRV_RST && r.drv1 == `FDCFG_DRV_RST)
    else $error("bank not at defaults after reset");

  chk_soft_keeps_bank: assert property (soft_rst && !wr_data |=>
    $stable(r.mode) && $stable(r.option) && $stable(r.dtype) &&
    $stable(r.drv0) && $stable(r.drv1))
    else $error("soft reset changed the bank");

  chk_floppy_mode_wr: assert property (wr_data && r.index == `FDCFG_IDX_MODE |=>
    enhanced_mode == $past(io_wdata[0]))
    else $error("floppy mode bit not taken");

  chk_dma_style_wr: assert property (wr_data && r.index == `FDCFG_IDX_MODE |=>
    non_burst_dma == $past(io_wdata[1]))
    else $error("dma style bit not taken");

  chk_iface_mode_wr: assert property (wr_data && r.index == `FDCFG_IDX_MODE |=>
    interface_mode == $past(io_wdata[3:2]))
    else $error("interface mode not taken");

  chk_open_drain_oe: assert property (open_drain_driver && fdc_active |=>
    fdc_pin_oe == ~$past(core_pin_out) && fdc_pin_out == '0)
    else $error("open drain pin drives high");

  chk_tristate_pins: assert property (!fdc_active |=> fdc_pin_oe == '0)
    else $error("tri-stated pins still driven");

  chk_pp_pins_free: assert property (pp_route_en |=>
    pp_pin_oe == '1 && pp_pin_out == $past(pp_core_pin_out))
    else $error("parallel route pins affected by mode");

  chk_force_wp_sel: assert property (r.option[0] && !drive_select1_n |=>
    !core_write_protect_n)
    else $error("forced write protect missing");

  chk_global_wp: assert property (floppy_write_protect |=> !core_write_protect_n)
    else $error("global write protect not reflected");

  chk_sra_wp: assert property (status_register_a_wp != core_write_protect_n)
    else $error("status bit differs from core write protect");

  chk_pp_force_wp: assert property (r.option[0] && !pp_drive_select0_n |=>
    !pp_core_write_protect_n)
    else $error("parallel route force missing");

  chk_density_high: assert property (r.option[3:2] == `FDCFG_DEN_HIGH |=> density_out)
    else $error("density not forced high");

  chk_density_pass: assert property (!r.option[3] |=> density_out == $past(core_density))
    else $error("density not passed through");

  chk_type_b_wr: assert property (wr_data && r.index == `FDCFG_IDX_TYPE |=>
    drive_type_b == $past(io_wdata[3:2]) && r.dtype[7:6] == $past(io_wdata[7:6]))
    else $error("drive type storage not taken");

  chk_rsvd_reads_zero: assert property (rd_data && r.index == `FDCFG_IDX_RSVD |=>
    io_rvalid && io_rdata == 8'h00)
    else $error("reserved index read not zero");

  chk_drv0_ro_zero: assert property (rd_data && r.index == `FDCFG_IDX_DRV0 |=>
    io_rvalid && io_rdata[7] == 1'b0 && io_rdata[5] == 1'b0 && io_rdata[2] == 1'b0)
    else $error("read-only bits of drive zero not zero");

  chk_precomp_wr: assert property (wr_data && r.index == `FDCFG_IDX_DRV0 |=>
    drive0_precomp_off == $past(io_wdata[6]))
    else $error("precompensation bit not taken");

  chk_drv1_fields: assert property (wr_data && r.index == `FDCFG_IDX_DRV1 |=>
    drive1_rate_table_select == $past(io_wdata[4:3]) && r.drv1[7] == 1'b0)
    else $error("drive one register wrong");

  chk_boot_drive: assert property (boot_drive == 1'b0)
    else $error("boot drive not drive zero");

  chk_ro_bits_kept: assert property (wr_data && r.index == `FDCFG_IDX_DRV0 |=>
    (r.drv0 & ~`FDCFG_DRV_MASK) == 8'h00)
    else $error("read-only bit stored");

  // main scenarios
  cov_mode_write:  cover property (wr_data && r.index == `FDCFG_IDX_MODE);
  cov_forced_wp:   cover property (r.option[0] && !drive_select0_n ##1 !core_write_protect_n);
  cov_index_read:  cover property (io_wr && !io_data_sel ##2 rd_data ##1 io_rvalid);
  cov_tristate:    cover property (!fdc_active ##1 fdc_pin_oe == '0);

endmodule : fdcfg_config_regs

/* dv/fdcfg_host.sv */
// fdcfg_host: host software model on the configuration index/data port.
// assumes the bank samples requests on the rising edge of clk.
`include "fdcfg_consts.svh"

module fdcfg_host (
  // clock
  input  wire logic       clk,
  // port requests
  output logic            io_wr,
  output logic            io_rd,
  output logic            io_data_sel,
  output logic      [7:0] io_wdata,
  // answers
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // idle port at time zero
  initial begin
    io_wr       = 1'b0;
    io_rd       = 1'b0;
    io_data_sel = 1'b0;
    io_wdata    = 8'h00;
  end

  // one write strobe held across one rising edge
  task automatic put(input logic sel, input logic [7:0] d);
    @(negedge clk);
    io_wr       = 1'b1;
    io_data_sel = sel;
    io_wdata    = d;
    @(negedge clk);
    io_wr    = 1'b0;
    io_wdata = ~d; // released bus must not show a stale value
  endtask : put

  // register write: index first, then data
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    put(1'b0, idx);
    put(1'b1, (idx == `FDCFG_IDX_MODE) ? (d & 8'hDF) : d);
  endtask : wr

  // register read: index, then data read, answer awaited under a bound
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    int n;
    put(1'b0, idx);
    @(negedge clk);
    io_rd       = 1'b1;
    io_data_sel = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    n     = 0;
    while (io_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (io_rvalid === 1'b1) ? io_rdata : 8'hXX;
  endtask : rd
endmodule : fdcfg_host

/* dv/floppy_ldev_config_regs_tb.sv */
// floppy_ldev_config_regs_tb: self-checking bench of the floppy config bank.
// assumes fdcfg_host drives the port; other inputs change at falling edges.
`include "fdcfg_consts.svh"

module floppy_ldev_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fdcfg_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} fdcfg_row_s;
  logic       clk, rst, soft_rst, ldev, wpi, ds0, ds1, gwp, den_in, ppen;
  logic [7:0] cpin, ppin, v, fo, fe, po, pe, rdat;
  logic [1:0] ifm, ta, tbt, d0t, d0r, d1t, d1r;
  logic       rv, enh, nbd, d0p, d1p, boot, cwp, status_register_a, pcwp, den;
  wire        wr, rd, sel;
  wire  [7:0] wd;
  int         failures, n_checks, i;
  fdcfg_row_s rows [6] = '{'{8'hF0, 8'h45, 8'h45}, '{8'hF1, 8'h0D, 8'h0D},
    '{8'hF2, 8'hA5, 8'hA5}, '{8'hF3, 8'hFF, 8'h00}, '{8'hF4, 8'hFF, 8'h5B},
    '{8'hF5, 8'hF7, 8'h53}};
  logic [7:0] dflt [6] = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  // global wp, pin, ds0_n, ds1_n, force, expected wp_n
  logic [5:0] wpc  [6] = '{6'b011111, 6'b111100, 6'b001100, 6'b010101,
    6'b010110, 6'b011010};

  ////////////////////////////////////////////////////////////////////////////
  // design, host model and clock
  fdcfg_config_regs dut_u (.clk(clk), .rst(rst), .soft_rst(soft_rst), .io_wr(wr),
    .io_rd(rd), .io_data_sel(sel), .io_wdata(wd), .ldev_active(ldev), .io_rdata(rdat),
    .io_rvalid(rv), .enhanced_mode(enh), .non_burst_dma(nbd), .interface_mode(ifm),
    .drive_type_a(ta), .drive_type_b(tbt), .drive0_type_select(d0t),
    .drive0_rate_table_select(d0r), .drive0_precomp_off(d0p), .drive1_type_select(d1t),
    .drive1_rate_table_select(d1r), .drive1_precomp_off(d1p), .boot_drive(boot),
    .write_protect_n_input(wpi), .drive_select0_n(ds0), .drive_select1_n(ds1),
    .floppy_write_protect(gwp), .core_write_protect_n(cwp), .status_register_a_wp(status_register_a),
    .pp_write_protect_n_input(wpi), .pp_drive_select0_n(ds0), .pp_drive_select1_n(ds1),
    .pp_core_write_protect_n(pcwp), .core_density(den_in), .density_out(den),
    .core_pin_out(cpin), .fdc_pin_out(fo), .fdc_pin_oe(fe), .pp_route_en(ppen),
    .pp_core_pin_out(ppin), .pp_pin_out(po), .pp_pin_oe(pe));
  fdcfg_host host_u (.clk(clk), .io_wr(wr), .io_rd(rd), .io_data_sel(sel),
    .io_wdata(wd), .io_rdata(rdat), .io_rvalid(rv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, reset and verdict helpers
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hard_reset();
    rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
  endtask : hard_reset
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {soft_rst, gwp, den_in} = 3'h0;
    {ldev, wpi, ds0, ds1, ppen} = 5'h1F;
    cpin = 8'hA5;
    ppin = 8'h3C;
    failures = 0;
    n_checks = 0;
    hard_reset();
    for (i = 0; i < 6; i++) begin
      host_u.rd(8'hF0 + i[7:0], v);
      chk("default", v, dflt[i]);
    end
    for (i = 0; i < 6; i++) begin
      host_u.wr(rows[i].idx, rows[i].wd);
      host_u.rd(rows[i].idx, v);
      chk("readback", v, rows[i].rd);
    end
    chk("mode", {4'h0, enh, nbd, ifm}, 8'h09);
    chk("fdc pp out", fo, 8'hA5);
    chk("fdc pp oe", fe, 8'hFF);
    chk("types", {4'h0, tbt, ta}, 8'h05);
    chk("drv0", {3'h0, d0p, d0r, d0t}, 8'h1F);
    chk("drv1", {3'h0, d1p, d1r, d1t}, 8'h1B);
    chk("boot", {7'h0, boot}, 8'h00);
    host_u.wr(`FDCFG_IDX_MODE, 8'h81);
    repeat (2) @(negedge clk);
    chk("tri oe", fe, 8'h00);
    chk("pp route", {po ^ ppin, pe}, {8'h00, 8'hFF});
    host_u.wr(`FDCFG_IDX_MODE, 8'h00);
    repeat (2) @(negedge clk);
    chk("od oe", fe, ~cpin);
    chk("od out", fo, 8'h00);
    for (i = 0; i < 8; i++) begin
      den_in = i[0];
      host_u.wr(`FDCFG_IDX_OPTION, {4'h0, i[2:1], 2'h0});
      repeat (2) @(negedge clk);
      chk("density", {7'h0, den}, (i[2:1] == 2'h2) ? 8'h01 : (i[2:1] == 2'h3) ? 8'h00 :
        {7'h0, i[0]});
    end
    for (i = 0; i < 6; i++) begin
      host_u.wr(`FDCFG_IDX_OPTION, {7'h0, wpc[i][1]});
      {gwp, wpi, ds0, ds1} = wpc[i][5:2];
      repeat (6) @(negedge clk);
      chk("wp", {5'h0, cwp, status_register_a, pcwp}, {5'h0, wpc[i][0], ~wpc[i][0], wpc[i][0]});
    end
    ldev = 1'b0;
    host_u.wr(`FDCFG_IDX_TYPE, 8'h11);
    ldev = 1'b1;
    @(negedge clk);
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    host_u.rd(`FDCFG_IDX_TYPE, v);
    chk("soft keeps", v, 8'hA5);
    hard_reset();
    host_u.rd(`FDCFG_IDX_MODE, v);
    chk("hard clears", v, 8'h0E);
    tally_and_finish();
  end
endmodule : floppy_ldev_config_regs_tb
